// ===== ccr_pkg.sv
// Package for the CPU core control register block.
// Assumes a 32-bit APB slave with one aligned word per register.
package ccr_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] CCR_CORE_CTRL_ADDR  = 12'h000;
    localparam logic [11:0] CCR_PRIO_LEVEL_ADDR = 12'h004;
    localparam int          CCR_REG_WIDTH       = 16;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int          CCR_PRIO_FLAG_BIT  = 3;
    localparam int          CCR_PSV_BIT        = 2;
    localparam logic        CCR_PSV_RESET      = 1'h0;
    localparam logic [3:0]  CCR_LEVEL_RESET    = 4'h0;
    localparam logic [3:0]  CCR_LEVEL_MAX_USER = 4'h7;
    localparam logic [31:0] CCR_ZERO_WORD      = 32'h0000_0000;
    localparam logic [31:0] CCR_IMPL_MASK      = 32'h0000_000C;
    localparam int          CCR_WORD_WIDTH     = 32;
    localparam int          CCR_LEVEL_WIDTH    = 4;
    localparam int          CCR_LEVEL_MSB      = 3;
    localparam int          CCR_LEVEL_LSB      = 0;
endpackage

// ===== ccr_core_ctrl.sv
// CPU core control register with its APB slave port.
// Assumes the interrupt controller supplies the current priority level and honours the gate.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module ccr_core_ctrl
    import ccr_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt controller side
    input  wire logic [3:0]  cpu_priority_level,
    input  wire logic        user_irq_req,
    output logic             user_irq_take,
    output logic             program_space_map_en
);
    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic wr_ccr;
    logic acc_phase;
    logic map_hit;
    assign acc_phase = psel && penable;
    assign map_hit   = (paddr == CCR_CORE_CTRL_ADDR) || (paddr == CCR_PRIO_LEVEL_ADDR);
    assign wr_ccr    = acc_phase && pwrite && (paddr == CCR_CORE_CTRL_ADDR);
    // Zero wait states keep the slave simple
    assign pready    = 1'h1;
    assign pslverr   = acc_phase && !map_hit;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic       program_space_window_enable_q;
    logic       priority_above_seven_flag_q;
    logic [CCR_LEVEL_WIDTH-1:0] level_q;

    // Only bit 2 is writable; all other write bits are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_space_window_enable_q <= CCR_PSV_RESET;
        end else if (wr_ccr) begin
            program_space_window_enable_q <= pwdata[CCR_PSV_BIT];
        end
    end

    // Flag follows the level only; the bus never writes it, so traps stay unmaskable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            priority_above_seven_flag_q <= 1'h0;
            level_q                     <= CCR_LEVEL_RESET;
        end else begin
            priority_above_seven_flag_q <= cpu_priority_level > CCR_LEVEL_MAX_USER;
            level_q                     <= cpu_priority_level;
        end
    end

    assign program_space_map_en = program_space_window_enable_q;
    assign user_irq_take = user_irq_req && !priority_above_seven_flag_q;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        prdata = CCR_ZERO_WORD;
        if (acc_phase && !pwrite && paddr == CCR_CORE_CTRL_ADDR) begin
            prdata[CCR_PRIO_FLAG_BIT] = priority_above_seven_flag_q;
            prdata[CCR_PSV_BIT]       = program_space_window_enable_q;
        end else if (acc_phase && !pwrite && paddr == CCR_PRIO_LEVEL_ADDR) begin
            prdata[CCR_LEVEL_MSB:CCR_LEVEL_LSB] = level_q;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Check-side decode, kept apart from the datapath decode so that a slip
    // in one cannot hide itself in the other
    logic rd_core;
    logic rd_level;
    logic wr_level;
    logic acc_unmapped;
    assign rd_core      = acc_phase && !pwrite && (paddr == CCR_CORE_CTRL_ADDR);
    assign rd_level     = acc_phase && !pwrite && (paddr == CCR_PRIO_LEVEL_ADDR);
    assign wr_level     = acc_phase && pwrite && (paddr == CCR_PRIO_LEVEL_ADDR);
    assign acc_unmapped = acc_phase && (paddr != CCR_CORE_CTRL_ADDR)
                          && (paddr != CCR_PRIO_LEVEL_ADDR);

    // ----------------------------------------
    // Per-bit reference view of the core word
    // ----------------------------------------
    // Built bit by bit so the read checks do not lean on the read mux
    logic [CCR_WORD_WIDTH-1:0] core_view;
    genvar gi;
    generate
        for (gi = 0; gi < CCR_WORD_WIDTH; gi++) begin : g_view
            if (gi == CCR_PRIO_FLAG_BIT) begin : g_flag
                assign core_view[gi] = priority_above_seven_flag_q;
            end else if (gi == CCR_PSV_BIT) begin : g_psv
                assign core_view[gi] = program_space_window_enable_q;
            end else begin : g_zero
                assign core_view[gi] = 1'h0;
            end
        end
    endgenerate

    // ----------------------------------------
    // Named sequences
    // ----------------------------------------
    // A bus write to the core word in its access cycle
    sequence s_core_write;
        wr_ccr;
    endsequence

    // A core write that clears the window enable bit
    sequence s_core_clear;
        wr_ccr && !pwdata[CCR_PSV_BIT];
    endsequence

    // The window enable shows the bit written on the edge before
    sequence s_window_took;
        program_space_map_en == $past(pwdata[CCR_PSV_BIT]);
    endsequence

    // The level has left the user range
    sequence s_level_high;
        cpu_priority_level > CCR_LEVEL_MAX_USER;
    endsequence

    // Flag up and user interrupts held off
    sequence s_gate_shut;
        priority_above_seven_flag_q && !user_irq_take;
    endsequence

    // ----------------------------------------
    // Priority flag and interrupt gate
    // ----------------------------------------
    property p_flag_tracks_level;
        @(posedge pclk) disable iff (!presetn)
        ##1 priority_above_seven_flag_q == ($past(cpu_priority_level) > CCR_LEVEL_MAX_USER);
    endproperty
    a_flag_tracks_level: assert property (p_flag_tracks_level)
        else $error("priority flag does not follow level");

    property p_irq_gate;
        @(posedge pclk) disable iff (!presetn)
        priority_above_seven_flag_q |-> !user_irq_take;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("user interrupt taken while flag set");

    property p_gate_after_high;
        @(posedge pclk) disable iff (!presetn)
        s_level_high |=> s_gate_shut;
    endproperty
    a_gate_after_high: assert property (p_gate_after_high)
        else $error("gate not shut after level rose above user range");

    property p_irq_pass;
        @(posedge pclk) disable iff (!presetn)
        (!priority_above_seven_flag_q && user_irq_req) |-> user_irq_take;
    endproperty
    a_irq_pass: assert property (p_irq_pass)
        else $error("user interrupt held off while flag clear");

    property p_take_needs_req;
        @(posedge pclk) disable iff (!presetn)
        user_irq_take |-> user_irq_req;
    endproperty
    a_take_needs_req: assert property (p_take_needs_req)
        else $error("interrupt taken with no request");

    property p_flag_no_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_ccr && pwdata[CCR_PRIO_FLAG_BIT] && cpu_priority_level <= CCR_LEVEL_MAX_USER)
            |=> !priority_above_seven_flag_q;
    endproperty
    a_flag_no_write: assert property (p_flag_no_write)
        else $error("software set priority flag");

    // ----------------------------------------
    // Window enable
    // ----------------------------------------
    property p_psv_write;
        @(posedge pclk) disable iff (!presetn)
        s_core_write |=> s_window_took;
    endproperty
    a_psv_write: assert property (p_psv_write)
        else $error("window enable not written");

    property p_psv_clear;
        @(posedge pclk) disable iff (!presetn)
        s_core_clear |=> !program_space_map_en;
    endproperty
    a_psv_clear: assert property (p_psv_clear)
        else $error("window enable not cleared");

    property p_psv_hold;
        @(posedge pclk) disable iff (!presetn)
        !wr_ccr |=> $stable(program_space_map_en);
    endproperty
    a_psv_hold: assert property (p_psv_hold)
        else $error("window enable changed without write");

    property p_level_write_kept;
        @(posedge pclk) disable iff (!presetn)
        (wr_level || acc_unmapped) |=> $stable(program_space_map_en);
    endproperty
    a_level_write_kept: assert property (p_level_write_kept)
        else $error("stray write changed window enable");

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    property p_unused_zero;
        @(posedge pclk) disable iff (!presetn)
        rd_core |-> (prdata & ~CCR_IMPL_MASK) == CCR_ZERO_WORD;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unimplemented bits read nonzero");

    property p_core_view;
        @(posedge pclk) disable iff (!presetn)
        rd_core |-> prdata == core_view;
    endproperty
    a_core_view: assert property (p_core_view)
        else $error("core word read differs from register state");

    property p_level_view;
        @(posedge pclk) disable iff (!presetn)
        rd_level |-> prdata == CCR_WORD_WIDTH'(level_q);
    endproperty
    a_level_view: assert property (p_level_view)
        else $error("level mirror read wrong");

    property p_quiet_zero;
        @(posedge pclk) disable iff (!presetn)
        (!rd_core && !rd_level) |-> prdata == CCR_ZERO_WORD;
    endproperty
    a_quiet_zero: assert property (p_quiet_zero)
        else $error("read data not zero outside a read");

    // ----------------------------------------
    // Bus answer and reset
    // ----------------------------------------
    property p_err_unmapped;
        @(posedge pclk) disable iff (!presetn)
        pslverr == acc_unmapped;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("error response on wrong access");

    property p_ready_high;
        @(posedge pclk) disable iff (!presetn)
        acc_phase |-> pready;
    endproperty
    a_ready_high: assert property (p_ready_high)
        else $error("access phase without ready");

    property p_reset_clear;
        @(posedge pclk)
        $rose(presetn) |-> (!program_space_map_en && !priority_above_seven_flag_q);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("implemented bits not clear after reset");
endmodule // ccr_core_ctrl

// ===== ccr_core_ctrl_tb.sv
// Testbench for the CPU core control register block.
// Assumes the zero-wait APB slave and registered priority flag of ccr_core_ctrl.
`timescale 1ns/1ps
module tb;
    import ccr_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, req, pready, pslverr, take, map_en, e, fm;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, lf;
    logic [3:0]  lvl;
    int          errors, num_checks, exp_psv, exp_flag, nw;
    int          exp_q[$];
    ccr_core_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_priority_level(lvl), .user_irq_req(req),
        .user_irq_take(take), .program_space_map_en(map_en));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask
    // Waits for pready as long as it takes; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        nw = 0;
        do begin @(posedge pclk); nw++; end while (pready !== 1'b1);
        r = prdata; e = pslverr; psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin pclk = 1'b0; forever #12.5 pclk = ~pclk; end
    initial begin repeat (4000) @(posedge pclk); errors++; give_verdict(); end
    initial begin
        {presetn, psel, penable, pwrite, req, paddr, pwdata, lvl} = '0;
        lf = 32'h13d6; errors = 0; num_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CCR_CORE_CTRL_ADDR, 32'h0);
        chk("reset_word", CCR_ZERO_WORD, r);
        chk("wait_states", 32'h1, 32'(nw));
        exp_psv = 0;
        exp_flag = 0;
        for (int i = 0; i < 10; i++) begin
            lf = lfsr(lf);
            lvl <= (i < 2) ? 4'h7 + 4'(i) : lf[7:4];
            req <= lf[4];
            apb(1'b1, CCR_CORE_CTRL_ADDR, lf);
            exp_psv = lf[CCR_PSV_BIT] ? 1 : 0;
            apb(1'b0, CCR_CORE_CTRL_ADDR, 32'h0);
            exp_flag = (lvl > CCR_LEVEL_MAX_USER) ? 1 : 0;
            exp_q.push_back((exp_flag << CCR_PRIO_FLAG_BIT) | (exp_psv << CCR_PSV_BIT));
            chk("core_word", exp_q.pop_front(), r);
            apb(1'b0, CCR_PRIO_LEVEL_ADDR, 32'h0);
            chk("level_word", 32'(lvl), r);
            @(negedge pclk);
            chk("map_en", exp_psv, 32'(map_en));
            chk("irq_take", (req && exp_flag == 0) ? 1 : 0, 32'(take));
            $display("test %0d done", i);
            @(posedge pclk);
        end
        apb(1'b1, CCR_PRIO_LEVEL_ADDR, 32'hFFFF_FFFF);
        apb(1'b1, 12'h0F0, (exp_psv != 0) ? 32'h0 : 32'h4);
        chk("slverr_wr", 32'h1, 32'(e));
        apb(1'b0, CCR_CORE_CTRL_ADDR, 32'h0);
        chk("kept_word", (exp_flag << CCR_PRIO_FLAG_BIT) | (exp_psv << CCR_PSV_BIT), r);
        apb(1'b0, 12'h0F0, 32'h0);
        chk("slverr", 32'h1, 32'(e));
        apb(1'b1, CCR_CORE_CTRL_ADDR, 32'h4);
        @(negedge pclk);
        chk("map_set", 32'h1, 32'(map_en));
        @(posedge pclk);
        presetn <= 1'b0; lvl <= 4'h0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("rereset_map", 32'h0, 32'(map_en));
        apb(1'b0, CCR_CORE_CTRL_ADDR, 32'h0);
        chk("rereset_word", CCR_ZERO_WORD, r);
        give_verdict();
    end
endmodule // tb
